// [core/fsp_config_regs.sv]
// Purpose: segment select, protocol/drive configuration and ready flag registers
// Assumes: host serial clock sclk frames commands while csN is low, msb first, one line
// Notes:   registers live on ref_clk; link bytes cross by toggle handshake
//
// Behaviour
// (R1) segment bit 0: 0 lower half (default), 1 upper half
// (R2) program and erase with 3-byte address target selected segment
// (R3) bulk erase covers whole array regardless of segment bit
// (R4) continuous read starts in segment, wraps through other segment to zero
// (R5) read crossing segment boundary leaves stored segment bit unchanged
// (R6) segment register supplies address bits 31:24; only bit 24 implemented
// (R7) at power-up segment bit loads from nonvolatile config bit 1
// (R8) write-segment command updates the segment bit at any time
// (R9) in 4-byte mode the register is ignored, command address used
// (R10) config bit 7 low enables quad; resets high
// (R11) config bit 6 low enables dual; resets high
// (R12) both bits low selects quad over dual
// (R13) protocol change applies only after write command completes
// (R14) config bit 4 high enables hold/reset pin; resets high
// (R15) config bit 3 low enables supply acceleration; resets high
// (R16) config writes take effect when the write command completes
// (R17) config readable and writable in every protocol
// (R18) flag bit 7 low while program/erase/register write busy, high ready
// (R19) status flag bits clear themselves; no error bits kept here
// (R20) reserved bits read zero and ignore writes
// (R21) drive strength field stored as written, resets to all ones
`timescale 1ns/1ns
module fsp_config_regs #(
    parameter int ADDR_W = 25
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire logic              nvcSegDefault,
    input  wire logic              sclk,
    input  wire logic              csN,
    input  wire logic              mosi,
    output logic                   miso,
    output logic                   misoOeN,
    input  wire logic              fourByteMode,
    input  wire logic              progBusy,
    input  wire logic              eraseBusy,
    input  wire logic              regWriteBusy,
    input  wire logic              bulkErase,
    input  wire logic              readStart,
    input  wire logic              readAdvance,
    input  wire logic [31:0]       cmdAddr,
    output logic [ADDR_W-1:0]      arrayAddr,
    output logic                   eraseAll,
    output fsp_pkg::fsp_proto_t    protoMode,
    output logic                   holdEnable,
    output logic                   accelEnableN,
    output logic [fsp_pkg::DRV_W-1:0] driveStrength
);

    // ****************************************************************
    // link side: shift in bytes on sclk
    // ****************************************************************
    logic [2:0]  bitCnt_r;
    logic [6:0]  shIn_r;
    logic [7:0]  linkByte_r;
    logic        linkTgl_r;
    logic        linkFirst_r;
    logic        linkIsFirst_r;
    logic [7:0]  txSh_r;
    wire  [7:0]  rxByte = {shIn_r, mosi};
    wire         byteDone = (bitCnt_r == 3'h7);

    // the link clock stops between frames, so the frame's own csN resets it
    always_ff @(posedge sclk or posedge csN)
    begin
        if (csN)
        begin
            bitCnt_r    <= 3'h0;
            shIn_r      <= 7'h00;
            linkFirst_r <= 1'b1;
        end
        else
        begin
            bitCnt_r <= bitCnt_r + 3'h1;
            shIn_r   <= rxByte[6:0];
            if (byteDone)
            begin
                linkFirst_r <= 1'b0;
            end
        end
    end

    // byte hand-off holds until the next byte, far longer than a sync round trip
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            linkByte_r    <= 8'h00;
            linkTgl_r     <= 1'b0;
            linkIsFirst_r <= 1'b0;
        end
        else if (!csN && byteDone)
        begin
            linkByte_r    <= rxByte;
            linkIsFirst_r <= linkFirst_r;
            linkTgl_r     <= ~linkTgl_r;
        end
    end

    // ****************************************************************
    // crossings into ref_clk
    // ****************************************************************
    logic [2:0] tglSync_r;
    logic [1:0] csSync_r;
    logic [1:0] nvcSync_r;
    wire        byteEvt  = tglSync_r[2] ^ tglSync_r[1];
    wire        frameEnd = csSync_r[1];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tglSync_r <= 3'h0;
            csSync_r  <= 2'h3;
            nvcSync_r <= 2'h0;
        end
        else if (clkEn)
        begin
            tglSync_r <= {tglSync_r[1:0], linkTgl_r};
            csSync_r  <= {csSync_r[0], csN};
            nvcSync_r <= {nvcSync_r[0], nvcSegDefault};
        end
    end

    // ****************************************************************
    // command decode and registers
    // ****************************************************************
    logic [7:0] opcode_r;
    logic [7:0] segReg_r;
    logic [7:0] cfgReg_r;
    logic [7:0] cfgPend_r;
    logic       cfgPendV_r;
    logic [1:0] strapCnt_r;
    logic       dataSeen_r;
    logic [7:0] readVal_r;

    wire        busy     = progBusy | eraseBusy | regWriteBusy;
    wire [7:0]  flagVal  = {~busy, 7'h00};                                // see (R18) (R19)
    wire        isOpcode = byteEvt & linkIsFirst_r;
    wire        isData   = byteEvt & ~linkIsFirst_r & ~dataSeen_r;
    wire        wrSeg    = isData & (opcode_r == fsp_pkg::CMD_WR_SEG);
    wire        wrCfg    = isData & (opcode_r == fsp_pkg::CMD_WR_CFG);
    wire [7:0]  rdSel    = (linkByte_r == fsp_pkg::CMD_RD_SEG) ? segReg_r :
                           (linkByte_r == fsp_pkg::CMD_RD_CFG) ? cfgReg_r :  // see (R17)
                           (linkByte_r == fsp_pkg::CMD_RD_FLG) ? flagVal : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opcode_r    <= 8'h00;
            dataSeen_r  <= 1'b0;
            readVal_r   <= 8'h00;
        end
        else if (clkEn)
        begin
            if (isOpcode)
            begin
                opcode_r   <= linkByte_r;
                dataSeen_r <= 1'b0;
                readVal_r  <= rdSel;
            end
            else if (isData)
            begin
                dataSeen_r <= 1'b1;
            end
        end
    end

    // strap taken after reset release, once the synchroniser holds the pin's value
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            segReg_r   <= 8'h00;
            strapCnt_r <= 2'h0;
        end
        else if (clkEn)
        begin
            if (strapCnt_r != 2'h3)
            begin
                segReg_r   <= {7'h00, nvcSync_r[1]};                      // see (R7)
                strapCnt_r <= strapCnt_r + 2'h1;
            end
            else if (wrSeg)
            begin
                segReg_r <= linkByte_r & fsp_pkg::SEG_MASK;               // see (R8) (R20)
            end
        end
    end

    // writes are held until csN rises, so the new protocol never hits the same frame
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfgReg_r   <= fsp_pkg::CFG_RST;                               // see (R10) (R11) (R14) (R15) (R21)
            cfgPend_r  <= 8'h00;
            cfgPendV_r <= 1'b0;
        end
        else if (clkEn)
        begin
            if (wrCfg)
            begin
                cfgPend_r  <= linkByte_r & fsp_pkg::CFG_MASK;             // see (R20) (R21)
                cfgPendV_r <= 1'b1;
            end
            else if (cfgPendV_r && frameEnd)
            begin
                cfgReg_r   <= cfgPend_r;                                  // see (R13) (R16)
                cfgPendV_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // configuration outputs
    // ****************************************************************
    wire quadOn = ~cfgReg_r[fsp_pkg::QUAD_BIT];
    wire dualOn = ~cfgReg_r[fsp_pkg::DUAL_BIT];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            protoMode     <= fsp_pkg::PROTO_EXT;
            holdEnable    <= 1'b1;
            accelEnableN  <= 1'b1;
            driveStrength <= {fsp_pkg::DRV_W{1'b1}};
        end
        else if (clkEn)
        begin
            protoMode     <= quadOn ? fsp_pkg::PROTO_QUAD :                // see (R12)
                             dualOn ? fsp_pkg::PROTO_DUAL : fsp_pkg::PROTO_EXT;
            holdEnable    <= cfgReg_r[fsp_pkg::HOLD_BIT];                 // see (R14)
            accelEnableN  <= cfgReg_r[fsp_pkg::ACCEL_BIT];                // see (R15)
            driveStrength <= cfgReg_r[fsp_pkg::DRV_LSB +: fsp_pkg::DRV_W];
        end
    end

    // ****************************************************************
    // array address generation
    // ****************************************************************
    // the read pointer is its own counter; segReg_r is never written by it
    logic [ADDR_W-1:0] addr_r;
    wire  [ADDR_W-1:0] addr3 = {segReg_r[fsp_pkg::SEG_BIT], cmdAddr[ADDR_W-2:0]};  // see (R1) (R2) (R6)
    wire  [ADDR_W-1:0] addr4 = cmdAddr[ADDR_W-1:0];
    wire  [ADDR_W-1:0] start = fourByteMode ? addr4 : addr3;             // see (R9)

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_r   <= '0;
            eraseAll <= 1'b0;
        end
        else if (clkEn)
        begin
            eraseAll <= bulkErase;                                        // see (R3)
            if (readStart)
            begin
                addr_r <= start;
            end
            else if (readAdvance)
            begin
                addr_r <= addr_r + 1'b1;                                  // see (R4) (R5)
            end
        end
    end

    assign arrayAddr = readStart ? start : addr_r;

    // ****************************************************************
    // read data out on the link, shifted on falling sclk
    // ****************************************************************
    logic       rdOn_r;
    logic [2:0] txCnt_r;

    // readVal_r settles many ref_clk cycles before the second byte starts
    always_ff @(negedge sclk or posedge csN)
    begin
        if (csN)
        begin
            txSh_r  <= 8'h00;
            txCnt_r <= 3'h0;
            rdOn_r  <= 1'b0;
        end
        else
        begin
            rdOn_r  <= ~linkFirst_r;
            txCnt_r <= txCnt_r + 3'h1;
            if (txCnt_r == 3'h0)
            begin
                // first data bit is already on the line straight from readVal_r
                txSh_r <= {readVal_r[6:0], 1'b0};
            end
            else
            begin
                txSh_r <= {txSh_r[6:0], 1'b0};
            end
        end
    end

    // no sclk edge falls in the host's gap, so the msb must not wait for one
    assign miso    = (txCnt_r == 3'h0) ? readVal_r[7] : txSh_r[7];
    assign misoOeN = csN | ~rdOn_r;

endmodule

// [core/fsp_pkg.sv]
// Purpose: constants for the segment/protocol configuration register group
// Assumes: 8-bit registers reached by serial commands
// Notes:   command codes are this block's own encoding on its command port
package fsp_pkg;

    // ****************************************************************
    // register fields
    // ****************************************************************
    localparam int SEG_BIT      = 0;
    localparam int QUAD_BIT     = 7;
    localparam int DUAL_BIT     = 6;
    localparam int HOLD_BIT     = 4;
    localparam int ACCEL_BIT    = 3;
    localparam int DRV_LSB      = 0;
    localparam int DRV_W        = 3;
    localparam int READY_BIT    = 7;
    localparam int NVC_SEG_BIT  = 1;
    localparam logic [7:0] CFG_RST   = 8'hdf;
    localparam logic [7:0] CFG_MASK  = 8'hdf;
    localparam logic [7:0] SEG_MASK  = 8'h01;

    // ****************************************************************
    // commands seen on the link, one opcode byte then data
    // ****************************************************************
    localparam logic [7:0] CMD_WR_SEG = 8'hc5;
    localparam logic [7:0] CMD_RD_SEG = 8'hc8;
    localparam logic [7:0] CMD_WR_CFG = 8'h61;
    localparam logic [7:0] CMD_RD_CFG = 8'h65;
    localparam logic [7:0] CMD_RD_FLG = 8'h70;

    typedef enum logic [1:0] {
        PROTO_EXT  = 2'h0,
        PROTO_DUAL = 2'h1,
        PROTO_QUAD = 2'h2
    } fsp_proto_t;

endpackage

// [bench/fsp_config_regs_assertions.sv]
// Purpose: port checks for the segment/protocol register group
// Assumes: raw csN is slow against ref_clk, frames well apart
// Notes:   link timing is judged by the bench
`timescale 1ns/1ns
module fsp_config_regs_assertions #(
    parameter int ADDR_W = 25
) (
    input wire logic                      ref_clk,
    input wire logic                      rst_n,
    input wire logic                      clkEn,
    input wire logic                      csN,
    input wire logic                      fourByteMode,
    input wire logic                      bulkErase,
    input wire logic                      readStart,
    input wire logic                      readAdvance,
    input wire logic [31:0]               cmdAddr,
    input wire logic [ADDR_W-1:0]         arrayAddr,
    input wire logic                      eraseAll,
    input wire fsp_pkg::fsp_proto_t       protoMode,
    input wire logic                      holdEnable,
    input wire logic                      accelEnableN,
    input wire logic [fsp_pkg::DRV_W-1:0] driveStrength
);
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_erase_copy: assert property (bulkErase |=> eraseAll) else $error("erase pulse lost");
    chk_erase_idle: assert property (!bulkErase |=> !eraseAll) else $error("stray erase");
    chk_addr_three: assert property (readStart && !fourByteMode |-> arrayAddr[23:0] == cmdAddr[23:0])
        else $error("low address bytes wrong");
    chk_addr_four: assert property (readStart && fourByteMode |-> arrayAddr == cmdAddr[ADDR_W-1:0])
        else $error("full address not used");
    chk_read_step: assert property (clkEn && readAdvance && !readStart |=> arrayAddr == $past(arrayAddr) + 1'b1)
        else $error("read address did not step");
    chk_read_hold: assert property (clkEn && !readAdvance ##1 !readStart |-> $stable(arrayAddr))
        else $error("read address moved");
    // csN is seen raw, so a change must follow a frame end
    chk_proto_frame: assert property ($changed(protoMode) |-> $past(csN)) else $error("protocol changed in frame");
    chk_cfg_frame: assert property ($changed({holdEnable, accelEnableN, driveStrength}) |-> $past(csN))
        else $error("config changed in frame");
endmodule

// [bench/fsp_host_model.sv]
// Purpose: serial host that frames one opcode and one data byte
// Assumes: sclk idles low, 6 ns period inside frames only
// Notes:   gap after the opcode lets the register clock fetch read data
`timescale 1ns/1ns
module fsp_host_model (
    output logic      sclk,
    output logic      csN,
    output logic      mosi,
    input  wire logic miso
);
    // ****************************************************************
    // framing
    // ****************************************************************
    initial
    begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end

    // one command per frame, msb first
    task automatic xfer(input logic [7:0] op, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        int          i;
        sh = {op, wd};
        rd = 8'h00;
        #1 csN = 1'b0;
        for (i = 0; i < 16; i++)
        begin
            if (i == 8)
                #32;
            mosi = sh[15-i];
            #3 sclk = 1'b1;
            if (i > 7)
                rd = {rd[6:0], miso};
            #3 sclk = 1'b0;
        end
        #3 csN = 1'b1;
        mosi = ~mosi; // released line must not keep its last value
        #40;
    endtask
endmodule

// [bench/fsp_config_regs_tb.sv]
// Purpose: register bench for the segment/protocol configuration group
// Assumes: host model drives the link, bench drives the rest at falling ref_clk
// Notes:   miso line is pulled up while the block does not drive it
`timescale 1ns/1ns
module fsp_config_regs_tb;
    logic                   ref_clk, rst_n, clkEn, nvcSegDefault, sclk, csN, mosi, miso, misoOeN;
    logic                   fourByteMode, progBusy, eraseBusy, regWriteBusy, bulkErase, readStart, readAdvance;
    logic [31:0]            cmdAddr;
    logic [24:0]            arrayAddr;
    logic                   eraseAll, holdEnable, accelEnableN;
    fsp_pkg::fsp_proto_t    protoMode;
    logic [2:0]             driveStrength;
    logic [7:0]             rd;
    logic [7:0]             cfgVal [4] = '{8'hbf, 8'h62, 8'h25, 8'hd9};
    int                     badCount, testsRun;
    wire                    misoWire = misoOeN ? 1'b1 : miso;

    fsp_config_regs i_fsp_config_regs (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
        .nvcSegDefault(nvcSegDefault), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoOeN(misoOeN),
        .fourByteMode(fourByteMode), .progBusy(progBusy), .eraseBusy(eraseBusy), .regWriteBusy(regWriteBusy),
        .bulkErase(bulkErase), .readStart(readStart), .readAdvance(readAdvance), .cmdAddr(cmdAddr),
        .arrayAddr(arrayAddr), .eraseAll(eraseAll), .protoMode(protoMode), .holdEnable(holdEnable),
        .accelEnableN(accelEnableN), .driveStrength(driveStrength));
    fsp_host_model i_fsp_host_model (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(misoWire));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            badCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdreg(input logic [7:0] op, input logic [7:0] exp);
        i_fsp_host_model.xfer(op, 8'h00, rd);
        check("register read", rd, exp);
    endtask

    task automatic startRead(input logic [31:0] a, input logic [24:0] exp);
        @(negedge ref_clk);
        cmdAddr   = a;
        readStart = 1'b1;
        #1 check("arrayAddr", arrayAddr, exp);
        @(negedge ref_clk);
        readStart = 1'b0;
    endtask

    task automatic printVerdict;
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    initial
    begin
        #30000 badCount++;
        printVerdict();
    end

    initial
    begin
        {rst_n, fourByteMode, progBusy, eraseBusy, regWriteBusy, bulkErase, readStart, readAdvance} = 8'h00;
        {clkEn, nvcSegDefault} = 2'h3;
        cmdAddr = 32'h0;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("reset outputs", {protoMode, holdEnable, accelEnableN, driveStrength}, 7'h1f);
        rdreg(fsp_pkg::CMD_RD_CFG, fsp_pkg::CFG_RST);
        rdreg(fsp_pkg::CMD_RD_SEG, 8'h01);
        i_fsp_host_model.xfer(fsp_pkg::CMD_WR_SEG, 8'hfe, rd);
        rdreg(fsp_pkg::CMD_RD_SEG, 8'h00);
        i_fsp_host_model.xfer(fsp_pkg::CMD_WR_SEG, 8'h01, rd);
        startRead(32'h00ff_ffff, 25'h1ff_ffff);
        @(negedge ref_clk);
        readAdvance = 1'b1;
        @(negedge ref_clk);
        readAdvance = 1'b0;
        @(negedge ref_clk);
        check("wrapped address", arrayAddr, 25'h0);
        rdreg(fsp_pkg::CMD_RD_SEG, 8'h01);
        fourByteMode = 1'b1;
        startRead(32'h0012_3456, 25'h012_3456);
        fourByteMode = 1'b0;
        i_fsp_host_model.xfer(fsp_pkg::CMD_WR_SEG, 8'h00, rd);
        startRead(32'h0100_0010, 25'h000_0010);
        bulkErase = 1'b1;
        @(negedge ref_clk);
        bulkErase = 1'b0;
        check("eraseAll", eraseAll, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            i_fsp_host_model.xfer(fsp_pkg::CMD_WR_CFG, cfgVal[k], rd);
            repeat (4) @(negedge ref_clk);
            check("protoMode", protoMode, !cfgVal[k][7] ? 2'h2 : !cfgVal[k][6] ? 2'h1 : 2'h0);
            check("cfg outputs", {holdEnable, accelEnableN, driveStrength}, cfgVal[k][4:0]);
            rdreg(fsp_pkg::CMD_RD_CFG, cfgVal[k] & fsp_pkg::CFG_MASK);
        end
        i_fsp_host_model.xfer(8'h5a, 8'h00, rd);
        rdreg(fsp_pkg::CMD_RD_CFG, 8'hd9);
        for (int k = 0; k < 4; k++)
        begin
            @(negedge ref_clk);
            {progBusy, eraseBusy, regWriteBusy} = 3'h4 >> k;
            rdreg(fsp_pkg::CMD_RD_FLG, (k == 3) ? 8'h80 : 8'h00);
        end
        printVerdict();
    end
endmodule

bind fsp_config_regs fsp_config_regs_assertions #(.ADDR_W(ADDR_W)) i_fsp_config_regs_assertions (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .csN(csN), .fourByteMode(fourByteMode),
    .bulkErase(bulkErase), .readStart(readStart), .readAdvance(readAdvance), .cmdAddr(cmdAddr),
    .arrayAddr(arrayAddr), .eraseAll(eraseAll), .protoMode(protoMode), .holdEnable(holdEnable),
    .accelEnableN(accelEnableN), .driveStrength(driveStrength));
